// ===== rtl/stack_branch_pkg.sv
// constants, register map and encodings for the stack frame and branch executor
// ****************************************************************************
// ****************************************************************************
`default_nettype none

package stack_branch_pkg;

	// ************************************************************************
	// register map (byte addresses)
	// ************************************************************************
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_CONFIG  = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;
	localparam logic [7:0] ADDR_CLOCKS  = 8'h10;
	localparam logic [7:0] ADDR_XFERS   = 8'h14;
	localparam logic [7:0] ADDR_GPR0    = 8'h20;
	localparam logic [7:0] ADDR_PC      = 8'h40;
	localparam logic [7:0] ADDR_PSW     = 8'h44;
	localparam logic [7:0] GPR_SPAN     = 8'h20;

	// ************************************************************************
	// general register indices
	// ************************************************************************
	localparam logic [2:0] IDX_AW = 3'h0;
	localparam logic [2:0] IDX_SP = 3'h4;
	localparam logic [2:0] IDX_BP = 3'h5;
	localparam logic [2:0] IDX_IY = 3'h7;

	// ************************************************************************
	// status word layout
	// ************************************************************************
	localparam int unsigned POS_MD  = 15;
	localparam logic [15:0] PSW_POP_MASK = 16'h0fc0;
	localparam logic [15:0] PSW_RESET    = 16'h8000;

	// ************************************************************************
	// control and status fields
	// ************************************************************************
	localparam int unsigned POS_BUS16    = 0;
	localparam int unsigned POS_BUSY     = 0;
	localparam int unsigned POS_EMUL     = 1;
	localparam int unsigned POS_REFUSED  = 2;

	// ************************************************************************
	// step sizes and offsets
	// ************************************************************************
	localparam logic [15:0] WORD_STEP    = 16'h0002;
	localparam logic [15:0] REGSET_STEP  = 16'h0010;
	localparam logic [2:0]  REGSET_WORDS = 3'h7;
	localparam logic [2:0]  REGSET_SKIP  = 3'h3;

	// ************************************************************************
	// clock figures (slow = 8-bit bus or odd address)
	// ************************************************************************
	localparam logic [11:0] CLK_POPPSW_SLOW  = 12'd12;
	localparam logic [11:0] CLK_POPPSW_FAST  = 12'd8;
	localparam logic [11:0] CLK_POPREG_SLOW  = 12'd75;
	localparam logic [11:0] CLK_POPREG_FAST  = 12'd43;
	localparam logic [11:0] CLK_FC0_SLOW     = 12'd16;
	localparam logic [11:0] CLK_FC0_FAST     = 12'd12;
	localparam logic [11:0] CLK_FCN_SLOW     = 12'd23;
	localparam logic [11:0] CLK_FCN_FAST     = 12'd19;
	localparam logic [11:0] CLK_FCLVL_SLOW   = 12'd16;
	localparam logic [11:0] CLK_FCLVL_FAST   = 12'd8;
	localparam logic [11:0] CLK_REL_SLOW     = 12'd10;
	localparam logic [11:0] CLK_REL_FAST     = 12'd6;
	localparam logic [11:0] CLK_BR_REL       = 12'd12;
	localparam logic [11:0] CLK_BR_REG       = 12'd11;

	// ************************************************************************
	// operations and sequencer states
	// ************************************************************************
	typedef enum logic [2:0] {
		OP_POP_PSW  = 3'h0,
		OP_POP_REGS = 3'h1,
		OP_FRAME_MK = 3'h2,
		OP_FRAME_RL = 3'h3,
		OP_BR_REL16 = 3'h4,
		OP_BR_REL8  = 3'h5,
		OP_BR_REG   = 3'h6,
		OP_NONE     = 3'h7
	} op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STEP = 4'b0010,
		ST_MEM  = 4'b0100,
		ST_HOLD = 4'b1000
	} state_t;

endpackage

`default_nettype wire

// ===== rtl/cycle_timer.sv
// down counter that marks when an instruction's clock figure has elapsed
`default_nettype none

module cycle_timer #(
	parameter int unsigned WIDTH = 12
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] target,
	// status
	output logic                  expired
);

	logic [WIDTH-1:0] count_q;

	// load target minus one so the end falls on the target-th busy cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= target - WIDTH'(1);
		end else if (count_q != '0) begin
			count_q <= count_q - WIDTH'(1);
		end
	end

	assign expired = (count_q == '0);

endmodule

`default_nettype wire

// ===== rtl/stack_branch_exec.sv
// stack frame, status-word and near branch execution unit with apb registers
`default_nettype none

module stack_branch_exec (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// stack memory port
	output logic             mem_req,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	// emulation call markers
	input  wire logic        enter_emulation_break,
	input  wire logic        return_from_emulation,
	// state
	output logic             exec_busy
);

	// ************************************************************************
	// state
	// ************************************************************************
	stack_branch_pkg::state_t state_q;
	stack_branch_pkg::op_t    op_q;
	logic [15:0] gpr_q [8];
	logic [15:0] program_counter_q;
	logic [15:0] program_status_word_q;
	logic [15:0] local_area_size_q;
	logic [7:0]  nesting_level_q;
	logic        bus16_q;
	logic        emul_call_q;
	logic        refused_q;
	logic [11:0] clocks_q;
	logic [11:0] elapsed_q;
	logic [9:0]  xfers_q;
	logic [2:0]  phase_q;
	logic [2:0]  idx_q;
	logic [7:0]  loop_q;
	logic [15:0] temp_q;
	logic [15:0] hold_q;
	logic [31:0] prdata_q;
	logic        mem_req_q;
	logic        mem_we_q;
	logic [15:0] mem_addr_q;
	logic [15:0] mem_wdata_q;

	// ************************************************************************
	// apb decode
	// ************************************************************************
	wire        setup_ph    = psel && !penable;
	wire        wr_acc      = psel && penable && pwrite;
	wire        idle        = (state_q == stack_branch_pkg::ST_IDLE);
	wire        hit_ctrl    = (paddr == stack_branch_pkg::ADDR_CTRL);
	wire        hit_operand = (paddr == stack_branch_pkg::ADDR_OPERAND);
	wire        hit_config  = (paddr == stack_branch_pkg::ADDR_CONFIG);
	wire        hit_status  = (paddr == stack_branch_pkg::ADDR_STATUS);
	wire        hit_clocks  = (paddr == stack_branch_pkg::ADDR_CLOCKS);
	wire        hit_xfers   = (paddr == stack_branch_pkg::ADDR_XFERS);
	wire        hit_pc      = (paddr == stack_branch_pkg::ADDR_PC);
	wire        hit_psw     = (paddr == stack_branch_pkg::ADDR_PSW);
	wire        hit_gpr     = (paddr >= stack_branch_pkg::ADDR_GPR0) &&
	                          (paddr < stack_branch_pkg::ADDR_GPR0 + stack_branch_pkg::GPR_SPAN) &&
	                          (paddr[1:0] == 2'b00);
	wire [2:0]  gpr_sel     = paddr[4:2];
	wire        mapped      = hit_ctrl | hit_operand | hit_config | hit_status | hit_clocks |
	                          hit_xfers | hit_pc | hit_psw | hit_gpr;
	wire        start_req   = wr_acc && hit_ctrl;
	wire [2:0]  start_op    = pwdata[2:0];
	wire        start_ok    = start_req && idle && (start_op != stack_branch_pkg::OP_NONE);
	// architectural state is only writable while no instruction is running
	wire        arch_wr     = wr_acc && idle;

	wire [31:0] rd_status   = {29'h0, refused_q, emul_call_q, !idle};
	wire [31:0] rd_mux      =
		hit_ctrl    ? {29'h0, op_q} :
		hit_operand ? {8'h0, nesting_level_q, local_area_size_q} :
		hit_config  ? {31'h0, bus16_q} :
		hit_status  ? rd_status :
		hit_clocks  ? {20'h0, clocks_q} :
		hit_xfers   ? {22'h0, xfers_q} :
		hit_pc      ? {16'h0, program_counter_q} :
		hit_psw     ? {16'h0, program_status_word_q} :
		hit_gpr     ? {16'h0, gpr_q[gpr_sel]} : 32'h0000_0000;

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ************************************************************************
	// clock figures and documented transfer counts
	// ************************************************************************
	wire [15:0] sp          = gpr_q[stack_branch_pkg::IDX_SP];
	wire [15:0] bp          = gpr_q[stack_branch_pkg::IDX_BP];
	// fast figures only on the 16-bit bus with an even stack address
	wire        fast        = bus16_q && !sp[0];
	wire [11:0] extra_lvl   = 12'(nesting_level_q) - 12'd1;
	wire [11:0] fc_slow     = stack_branch_pkg::CLK_FCN_SLOW +
	                          12'(extra_lvl * stack_branch_pkg::CLK_FCLVL_SLOW);
	wire [11:0] fc_fast     = stack_branch_pkg::CLK_FCN_FAST +
	                          12'(extra_lvl * stack_branch_pkg::CLK_FCLVL_FAST);
	wire        lvl_zero    = (nesting_level_q == 8'h00);
	wire [2:0]  new_op      = start_op;
	logic [11:0] target;
	logic [9:0]  doc_xfers;

	always_comb begin
		target    = stack_branch_pkg::CLK_BR_REL;
		doc_xfers = 10'd0;
		case (new_op)
			stack_branch_pkg::OP_POP_PSW: begin
				target    = fast ? stack_branch_pkg::CLK_POPPSW_FAST : stack_branch_pkg::CLK_POPPSW_SLOW;
				doc_xfers = 10'd1;
			end
			stack_branch_pkg::OP_POP_REGS: begin
				target    = fast ? stack_branch_pkg::CLK_POPREG_FAST : stack_branch_pkg::CLK_POPREG_SLOW;
				doc_xfers = 10'(stack_branch_pkg::REGSET_WORDS);
			end
			stack_branch_pkg::OP_FRAME_MK: begin
				if (lvl_zero) begin
					target = fast ? stack_branch_pkg::CLK_FC0_FAST : stack_branch_pkg::CLK_FC0_SLOW;
				end else begin
					target = fast ? fc_fast : fc_slow;
				end
				doc_xfers = lvl_zero ? 10'd0 : 10'd1 + 10'(extra_lvl[8:0]) + 10'(extra_lvl[8:0]);
			end
			stack_branch_pkg::OP_FRAME_RL: begin
				target    = (bus16_q && !bp[0]) ? stack_branch_pkg::CLK_REL_FAST :
				            stack_branch_pkg::CLK_REL_SLOW;
				doc_xfers = 10'd1;
			end
			stack_branch_pkg::OP_BR_REL16: target = stack_branch_pkg::CLK_BR_REL;
			stack_branch_pkg::OP_BR_REL8:  target = stack_branch_pkg::CLK_BR_REL;
			stack_branch_pkg::OP_BR_REG:   target = stack_branch_pkg::CLK_BR_REG;
			default: target = stack_branch_pkg::CLK_BR_REL;
		endcase
	end

	logic expired;

	cycle_timer #(
		.WIDTH (12)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (start_ok),
		.target  (target),
		.expired (expired)
	);

	// ************************************************************************
	// sequencing helpers
	// ************************************************************************
	localparam logic [15:0] WORD_STEP_C = stack_branch_pkg::WORD_STEP;
	// the saved stack pointer slot sits between frame base and base word
	wire [15:0] regset_off  = (idx_q < stack_branch_pkg::REGSET_SKIP) ?
	                          16'({idx_q, 1'b0}) : 16'({idx_q, 1'b0}) + WORD_STEP_C;
	wire [2:0]  regset_dst  = (idx_q < stack_branch_pkg::REGSET_SKIP) ?
	                          stack_branch_pkg::IDX_IY - idx_q : 3'd6 - idx_q;
	wire [15:0] sext_disp   = {{8{local_area_size_q[7]}}, local_area_size_q[7:0]};
	wire [15:0] psw_popped  = (program_status_word_q & ~stack_branch_pkg::PSW_POP_MASK) |
	                          (mem_rdata & stack_branch_pkg::PSW_POP_MASK);
	wire        md_popped   = emul_call_q ? mem_rdata[stack_branch_pkg::POS_MD] : 1'b1;
	wire        ack         = (state_q == stack_branch_pkg::ST_MEM) && mem_ack;
	wire        finish      = (state_q == stack_branch_pkg::ST_HOLD) && expired;

	assign mem_req   = mem_req_q;
	assign mem_we    = mem_we_q;
	assign mem_addr  = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign exec_busy = !idle;

	// ************************************************************************
	// apb side registers
	// ************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q          <= 32'h0000_0000;
			bus16_q           <= 1'b0;
			local_area_size_q <= 16'h0000;
			nesting_level_q   <= 8'h00;
			refused_q         <= 1'b0;
			emul_call_q       <= 1'b0;
		end else begin
			if (setup_ph) begin
				prdata_q <= rd_mux;
			end
			if (arch_wr && hit_config) begin
				bus16_q <= pwdata[stack_branch_pkg::POS_BUS16];
			end
			if (arch_wr && hit_operand) begin
				local_area_size_q <= pwdata[15:0];
				nesting_level_q   <= pwdata[23:16];
			end
			if (start_req) begin
				refused_q <= !start_ok;
			end
			// a break in the same cycle as a return keeps the call open
			if (enter_emulation_break) begin
				emul_call_q <= 1'b1;
			end else if (return_from_emulation) begin
				emul_call_q <= 1'b0;
			end
		end
	end

	// ************************************************************************
	// sequencer
	// ************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q               <= stack_branch_pkg::ST_IDLE;
			op_q                  <= stack_branch_pkg::OP_NONE;
			for (int i = 0; i < 8; i++) begin
				gpr_q[i] <= 16'h0000;
			end
			program_counter_q     <= 16'h0000;
			program_status_word_q <= stack_branch_pkg::PSW_RESET;
			clocks_q              <= 12'h000;
			elapsed_q             <= 12'h000;
			xfers_q               <= 10'h000;
			phase_q               <= 3'h0;
			idx_q                 <= 3'h0;
			loop_q                <= 8'h00;
			temp_q                <= 16'h0000;
			hold_q                <= 16'h0000;
			mem_req_q             <= 1'b0;
			mem_we_q              <= 1'b0;
			mem_addr_q            <= 16'h0000;
			mem_wdata_q           <= 16'h0000;
		end else begin
			if (!idle) begin
				elapsed_q <= elapsed_q + 12'd1;
			end
			case (state_q)
				stack_branch_pkg::ST_IDLE: begin
					if (arch_wr && hit_gpr) begin
						gpr_q[gpr_sel] <= pwdata[15:0];
					end
					if (arch_wr && hit_pc) begin
						program_counter_q <= pwdata[15:0];
					end
					if (arch_wr && hit_psw) begin
						program_status_word_q <= pwdata[15:0];
					end
					if (start_ok) begin
						op_q      <= stack_branch_pkg::op_t'(start_op);
						xfers_q   <= doc_xfers;
						elapsed_q <= 12'd1;
						phase_q   <= 3'h0;
						idx_q     <= 3'h0;
						loop_q    <= lvl_zero ? 8'h00 : nesting_level_q - 8'h01;
						state_q   <= stack_branch_pkg::ST_STEP;
					end
				end
				stack_branch_pkg::ST_STEP: begin
					state_q <= stack_branch_pkg::ST_MEM;
					mem_req_q <= 1'b1;
					mem_we_q  <= 1'b0;
					case (op_q)
						stack_branch_pkg::OP_POP_PSW: begin
							if (phase_q == 3'h0) begin
								mem_addr_q <= sp;
							end else begin
								mem_req_q <= 1'b0;
								state_q   <= stack_branch_pkg::ST_HOLD;
							end
						end
						stack_branch_pkg::OP_POP_REGS: begin
							if (idx_q != stack_branch_pkg::REGSET_WORDS) begin
								mem_addr_q <= sp + regset_off;
							end else begin
								gpr_q[stack_branch_pkg::IDX_SP] <= sp + stack_branch_pkg::REGSET_STEP;
								mem_req_q <= 1'b0;
								state_q   <= stack_branch_pkg::ST_HOLD;
							end
						end
						stack_branch_pkg::OP_FRAME_MK: begin
							case (phase_q)
								3'h0: begin
									mem_we_q    <= 1'b1;
									mem_addr_q  <= sp - stack_branch_pkg::WORD_STEP;
									mem_wdata_q <= bp;
								end
								3'h1: begin
									if (loop_q != 8'h00) begin
										mem_addr_q <= bp - stack_branch_pkg::WORD_STEP;
									end else if (!lvl_zero) begin
										mem_we_q    <= 1'b1;
										mem_addr_q  <= sp - stack_branch_pkg::WORD_STEP;
										mem_wdata_q <= temp_q;
										phase_q     <= 3'h3;
									end else begin
										mem_req_q <= 1'b0;
										phase_q   <= 3'h4;
										state_q   <= stack_branch_pkg::ST_STEP;
									end
								end
								3'h2: begin
									mem_we_q    <= 1'b1;
									mem_addr_q  <= sp - stack_branch_pkg::WORD_STEP;
									mem_wdata_q <= hold_q;
								end
								default: begin
									gpr_q[stack_branch_pkg::IDX_BP] <= temp_q;
									gpr_q[stack_branch_pkg::IDX_SP] <= sp - local_area_size_q;
									mem_req_q <= 1'b0;
									state_q   <= stack_branch_pkg::ST_HOLD;
								end
							endcase
						end
						stack_branch_pkg::OP_FRAME_RL: begin
							if (phase_q == 3'h0) begin
								gpr_q[stack_branch_pkg::IDX_SP] <= bp;
								mem_addr_q <= bp;
							end else begin
								mem_req_q <= 1'b0;
								state_q   <= stack_branch_pkg::ST_HOLD;
							end
						end
						stack_branch_pkg::OP_BR_REL16: begin
							program_counter_q <= program_counter_q + local_area_size_q;
							mem_req_q <= 1'b0;
							state_q   <= stack_branch_pkg::ST_HOLD;
						end
						stack_branch_pkg::OP_BR_REL8: begin
							program_counter_q <= program_counter_q + sext_disp;
							mem_req_q <= 1'b0;
							state_q   <= stack_branch_pkg::ST_HOLD;
						end
						stack_branch_pkg::OP_BR_REG: begin
							program_counter_q <= gpr_q[local_area_size_q[2:0]];
							mem_req_q <= 1'b0;
							state_q   <= stack_branch_pkg::ST_HOLD;
						end
						default: begin
							mem_req_q <= 1'b0;
							state_q   <= stack_branch_pkg::ST_HOLD;
						end
					endcase
				end
				stack_branch_pkg::ST_MEM: begin
					if (ack) begin
						mem_req_q <= 1'b0;
						mem_we_q  <= 1'b0;
						state_q   <= stack_branch_pkg::ST_STEP;
						case (op_q)
							stack_branch_pkg::OP_POP_PSW: begin
								program_status_word_q <= {md_popped, psw_popped[14:0]};
								gpr_q[stack_branch_pkg::IDX_SP] <= sp + stack_branch_pkg::WORD_STEP;
								phase_q <= 3'h1;
							end
							stack_branch_pkg::OP_POP_REGS: begin
								gpr_q[regset_dst] <= mem_rdata;
								idx_q <= idx_q + 3'h1;
							end
							stack_branch_pkg::OP_FRAME_MK: begin
								case (phase_q)
									3'h0: begin
										gpr_q[stack_branch_pkg::IDX_SP] <= sp - stack_branch_pkg::WORD_STEP;
										temp_q  <= sp - stack_branch_pkg::WORD_STEP;
										phase_q <= 3'h1;
									end
									3'h1: begin
										hold_q  <= mem_rdata;
										phase_q <= 3'h2;
									end
									3'h2: begin
										gpr_q[stack_branch_pkg::IDX_SP] <= sp - stack_branch_pkg::WORD_STEP;
										gpr_q[stack_branch_pkg::IDX_BP] <= bp - stack_branch_pkg::WORD_STEP;
										loop_q  <= loop_q - 8'h01;
										phase_q <= 3'h1;
									end
									default: begin
										gpr_q[stack_branch_pkg::IDX_SP] <= sp - stack_branch_pkg::WORD_STEP;
										phase_q <= 3'h4;
									end
								endcase
							end
							stack_branch_pkg::OP_FRAME_RL: begin
								gpr_q[stack_branch_pkg::IDX_BP] <= mem_rdata;
								gpr_q[stack_branch_pkg::IDX_SP] <= sp + stack_branch_pkg::WORD_STEP;
								phase_q <= 3'h1;
							end
							default: begin
								phase_q <= 3'h1;
							end
						endcase
					end
				end
				stack_branch_pkg::ST_HOLD: begin
					// a slow memory stretches the instruction past its figure
					if (finish) begin
						clocks_q <= elapsed_q;
						state_q  <= stack_branch_pkg::ST_IDLE;
					end
				end
				default: begin
					mem_req_q <= 1'b0;
					state_q   <= stack_branch_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== tb/stack_branch_exec_assertions.sv
// port level checks for the stack and branch execution unit
`default_nettype none
module stack_branch_exec_assertions (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb side
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// memory side and state
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic        exec_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("ready low in access");
	a_err_unmapped: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
		else $error("no error on hole");
	a_err_mapped: assert property (psel && penable && paddr == 8'h44 |-> !pslverr)
		else $error("error on mapped word");
	a_start_busy: assert property (psel && penable && pwrite && paddr == 8'h00
		&& pwdata[2:0] != 3'h7 && !exec_busy |=> exec_busy)
		else $error("start not taken");
	a_busy_span: assert property ($rose(exec_busy) |-> exec_busy [*6])
		else $error("instruction too short");
	a_mem_hold: assert property (mem_req && !mem_ack
		|=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped");
	a_mem_gap: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request not released");
	a_req_in_op: assert property (mem_req |-> exec_busy)
		else $error("transfer outside instruction");
endmodule
bind stack_branch_exec stack_branch_exec_assertions chk_u (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_ack,
	.exec_busy);
`default_nettype wire

// ===== tb/stack_mem.sv
// behavioural stack memory on the far side of the memory port
`default_nettype none
module stack_mem (
	// clock and mode
	input wire logic         pclk,
	input wire logic         slow,
	// memory port
	input wire logic         mem_req,
	input wire logic         mem_we,
	input wire logic [15:0]  mem_addr,
	input wire logic [15:0]  mem_wdata,
	output logic [15:0]      mem_rdata,
	output logic             mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] m [0:32767];
	logic        w_q = 1'b0;
	// slow mode stalls one cycle per transfer
	assign mem_ack = mem_req && (!slow || w_q);
	// outside an answer the data lines show the inverse, never a stale word
	assign mem_rdata = mem_ack ? m[mem_addr[15:1]] : ~m[mem_addr[15:1]];
	always @(posedge pclk) begin
		w_q <= mem_req && !mem_ack;
		if (mem_req && mem_ack && mem_we)
			m[mem_addr[15:1]] <= mem_wdata;
	end
endmodule
`default_nettype wire

// ===== tb/stack_frame_branch_exec_test.sv
// register level tests of the stack and branch execution unit
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module stack_frame_branch_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_req, mem_we, mem_ack;
	logic pready, pslverr, exec_busy, slow = 0, brk_in = 0, ret_in = 0, e;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	int n_errors = 0, checks_done = 0;
	stack_branch_exec dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack, .enter_emulation_break(brk_in), .return_from_emulation(ret_in), .exec_busy);
	stack_mem mem_u (.pclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack);
	initial forever #2 pclk = ~pclk;
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		`CHK(r, x)
	endtask
	// polls busy under a bound so a stuck sequencer is caught
	task automatic run(input logic [2:0] op, input logic [31:0] opd);
		apb(8'h04, 1'b1, opd);
		apb(8'h00, 1'b1, {29'h0, op});
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 300 && exec_busy !== 1'b0; i++) @(posedge pclk);
		// a sequencer that never returns to idle counts as a mismatch
		`CHK(exec_busy, 1'b0)
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000 n_errors++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h44, 32'h0000_8000);
		apb(8'h30, 1'b1, 32'h0000_0100);
		mem_u.m[16'h0080] = 16'h0ac0;
		mem_u.m[16'h0081] = 16'h0000;
		for (int i = 0; i < 8; i++) mem_u.m[16'h0082 + i] = 16'ha000 + 16'(i);
		run(3'h0, 32'h0);
		rd(8'h44, 32'h0000_8ac0);
		rd(8'h30, 32'h0000_0102);
		rd(8'h10, 32'h0000_000c);
		rd(8'h14, 32'h0000_0001);
		@(posedge pclk) brk_in <= 1'b1;
		@(posedge pclk) brk_in <= 1'b0;
		apb(8'h08, 1'b1, 32'h0000_0001);
		run(3'h0, 32'h0);
		rd(8'h44, 32'h0000_0000);
		rd(8'h10, 32'h0000_0008);
		// software puts native mode back before leaving the emulation call
		apb(8'h44, 1'b1, 32'h0000_8000);
		rd(8'h44, 32'h0000_8000);
		@(posedge pclk) ret_in <= 1'b1;
		@(posedge pclk) ret_in <= 1'b0;
		run(3'h1, 32'h0);
		for (int i = 0; i < 7; i++) rd(8'h3c - 8'(4 * (i < 3 ? i : i + 1)),
			32'ha000 + 32'(i < 3 ? i : i + 1));
		rd(8'h30, 32'h0000_0114);
		rd(8'h10, 32'h0000_002b);
		apb(8'h34, 1'b1, 32'h0000_1000);
		apb(8'h30, 1'b1, 32'h0000_0800);
		mem_u.m[16'h07ff] = 16'h5555;
		mem_u.m[16'h07fe] = 16'h6666;
		slow <= 1'b1;
		run(3'h2, {8'h0, 8'h3, 16'h0010});
		`CHK({mem_u.m[16'h03ff], mem_u.m[16'h03fe]}, 32'h1000_5555)
		`CHK({mem_u.m[16'h03fd], mem_u.m[16'h03fc]}, 32'h6666_07fe)
		rd(8'h34, 32'h0000_07fe);
		rd(8'h30, 32'h0000_07e8);
		rd(8'h14, 32'h0000_0005);
		slow <= 1'b0;
		run(3'h3, 32'h0);
		rd(8'h34, 32'h0000_1000);
		rd(8'h30, 32'h0000_0800);
		rd(8'h10, 32'h0000_0006);
		apb(8'h08, 1'b1, 32'h0);
		run(3'h2, {16'h0, 16'h0004});
		rd(8'h30, 32'h0000_07fa);
		rd(8'h10, 32'h0000_0010);
		rd(8'h14, 32'h0000_0000);
		apb(8'h40, 1'b1, 32'h0000_fff0);
		run(3'h4, 32'h0000_0020);
		rd(8'h40, 32'h0000_0010);
		run(3'h5, 32'h0000_0080);
		rd(8'h40, 32'h0000_ff90);
		rd(8'h10, 32'h0000_000c);
		run(3'h6, 32'h0000_0003);
		rd(8'h40, 32'h0000_a004);
		rd(8'h10, 32'h0000_000b);
		rd(8'h18, 32'h0);
		`CHK(e, 1'b1)
		apb(8'h00, 1'b1, 32'h0000_0007);
		rd(8'h0c, 32'h0000_0004);
		conclude();
	end
endmodule
`default_nettype wire
